// ### rpc_pkg.sv
// shared constants of the rs-485 operator panel port
package rpc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATION  = 8'h00;
  localparam logic [7:0] OFS_BAUD     = 8'h04;
  localparam logic [7:0] OFS_FRAME    = 8'h08;
  localparam logic [7:0] OFS_PARITY   = 8'h0c;
  localparam logic [7:0] OFS_WAIT     = 8'h10;
  localparam logic [7:0] OFS_TERM     = 8'h14;
  localparam logic [7:0] OFS_PROTOCOL = 8'h18;
  localparam logic [7:0] OFS_CONTROL  = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_TX_DATA  = 8'h24;
  localparam logic [7:0] OFS_RX_DATA  = 8'h28;
  localparam logic [7:0] OFS_MSG_WAIT = 8'h2c;
  // reset values of the settings
  localparam logic [7:0]  RST_STATION  = 8'h00;
  localparam logic [8:0]  RST_BAUD     = 9'h0c0;
  localparam logic [3:0]  RST_FRAME    = 4'h1;
  localparam logic [1:0]  RST_PARITY   = 2'h2;
  localparam logic [13:0] RST_WAIT     = 14'h270f;
  localparam logic [1:0]  RST_TERM     = 2'h1;
  localparam logic        RST_PROTOCOL = 1'b0;
  localparam logic [7:0]  RST_MSG_WAIT = 8'h00;
  // legal setting values
  localparam logic [8:0]  BAUD_48      = 9'h030;
  localparam logic [8:0]  BAUD_96      = 9'h060;
  localparam logic [8:0]  BAUD_192     = 9'h0c0;
  localparam logic [8:0]  BAUD_384     = 9'h180;
  localparam logic [3:0]  FMT_1S8D     = 4'h0;
  localparam logic [3:0]  FMT_2S8D     = 4'h1;
  localparam logic [3:0]  FMT_1S7D     = 4'ha;
  localparam logic [3:0]  FMT_2S7D     = 4'hb;
  localparam logic [1:0]  PAR_NONE     = 2'h0;
  localparam logic [1:0]  PAR_ODD      = 2'h1;
  localparam logic [1:0]  PAR_EVEN     = 2'h2;
  localparam logic [13:0] WAIT_MAX_MS  = 14'h0096;
  localparam logic [13:0] WAIT_FROM_MSG = 14'h270f;
  localparam logic [1:0]  TERM_NONE    = 2'h0;
  localparam logic [1:0]  TERM_CR      = 2'h1;
  localparam logic [1:0]  TERM_CRLF    = 2'h2;
  localparam logic [7:0]  STN_MAX_LINK = 8'h1f;
  localparam logic [7:0]  STN_MAX_RTU  = 8'hf7;
  localparam logic [7:0]  CHAR_CR      = 8'h0d;
  localparam logic [7:0]  CHAR_LF      = 8'h0a;
  // timing
  localparam int CLOCK_HZ      = 50000000;
  localparam int BAUD_UNIT_BPS = 100;
  localparam int MS_PER_S      = 1000;
  localparam int GAP_BITS      = 35;
endpackage : rpc_pkg

// ### rpc_port.sv
// rs-485 operator panel port: settings, wishbone slave, transmitter and receiver
`timescale 1ns/100ps
// How it works
// - station number 0..31, or 0..247 under the rtu protocol; resets to 0
// - bit rate is baud setting times 100; only 48, 96, 192, 384; default 192
// - frame setting 0/1/10/11 picks stop bits 1/2 and data bits 8 or 7
// - parity setting 0 none, 1 odd, 2 even; default even
// - response waits 0..150 ms after request; 9999 takes wait from message
// - protocol setting 0 native ascii link, 1 rtu fieldbus; default native
// - changed settings other than the message wait take effect only after a port reset
// - no data exchange while settings are missing or invalid
// - only messages carrying own station number are answered
module rpc_port #(
  parameter int P_CLK_HZ = rpc_pkg::CLOCK_HZ
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // rs-485 line
  input  wire logic        i_receive_pair,
  output logic             o_transmit_pair,
  output logic             o_transmit_enable
);
  localparam int DIV_48  = P_CLK_HZ / (48 * rpc_pkg::BAUD_UNIT_BPS);
  localparam int DIV_96  = P_CLK_HZ / (96 * rpc_pkg::BAUD_UNIT_BPS);
  localparam int DIV_192 = P_CLK_HZ / (192 * rpc_pkg::BAUD_UNIT_BPS);
  localparam int DIV_384 = P_CLK_HZ / (384 * rpc_pkg::BAUD_UNIT_BPS);
  localparam int CYC_MS  = P_CLK_HZ / rpc_pkg::MS_PER_S;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_BITS = 3'b100
  } rpc_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_BITS = 2'b10
  } rpc_rx_e;

  // settings as written, and the copy the line really uses
  logic [7:0]  stn_ff, a_stn_ff;
  logic [8:0]  baud_ff, a_baud_ff;
  logic [3:0]  fmt_ff, a_fmt_ff;
  logic [1:0]  par_ff, a_par_ff;
  logic [13:0] wait_ff, a_wait_ff;
  logic [1:0]  term_ff, a_term_ff;
  logic        prot_ff, a_prot_ff;
  logic [7:0]  msgw_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic        perr_ff, ferr_ff, ovr_ff, match_ff;
  logic [7:0]  rxd_ff;
  logic        rxv_ff;

  // wishbone decode
  wire req      = i_wb_cyc & i_wb_stb & ~ack_ff;
  wire wr_lane  = i_wb_sel[0];
  wire hit_stn  = i_wb_adr == rpc_pkg::OFS_STATION;
  wire hit_baud = i_wb_adr == rpc_pkg::OFS_BAUD;
  wire hit_fmt  = i_wb_adr == rpc_pkg::OFS_FRAME;
  wire hit_par  = i_wb_adr == rpc_pkg::OFS_PARITY;
  wire hit_wait = i_wb_adr == rpc_pkg::OFS_WAIT;
  wire hit_term = i_wb_adr == rpc_pkg::OFS_TERM;
  wire hit_prot = i_wb_adr == rpc_pkg::OFS_PROTOCOL;
  wire hit_ctl  = i_wb_adr == rpc_pkg::OFS_CONTROL;
  wire hit_sts  = i_wb_adr == rpc_pkg::OFS_STATUS;
  wire hit_txd  = i_wb_adr == rpc_pkg::OFS_TX_DATA;
  wire hit_rxd  = i_wb_adr == rpc_pkg::OFS_RX_DATA;
  wire hit_msgw = i_wb_adr == rpc_pkg::OFS_MSG_WAIT;
  logic buf_ready;
  // a tx data write stalls until the buffer has room
  wire do_ack   = req & ~(i_wb_we & hit_txd & ~buf_ready);
  wire wr       = do_ack & i_wb_we;
  wire wr_lo    = wr & wr_lane;
  wire port_rst = wr_lo & hit_ctl & i_wb_dat[0];
  wire sts_clr  = wr_lo & hit_sts;
  wire rx_pop   = do_ack & ~i_wb_we & hit_rxd;
  wire buf_push = wr_lo & hit_txd;

  // validity of the active settings
  wire stn_ok  = a_stn_ff <= (a_prot_ff ? rpc_pkg::STN_MAX_RTU : rpc_pkg::STN_MAX_LINK);
  wire baud_ok = a_baud_ff == rpc_pkg::BAUD_48 || a_baud_ff == rpc_pkg::BAUD_96 ||
                 a_baud_ff == rpc_pkg::BAUD_192 || a_baud_ff == rpc_pkg::BAUD_384;
  wire fmt_ok  = a_fmt_ff == rpc_pkg::FMT_1S8D || a_fmt_ff == rpc_pkg::FMT_2S8D ||
                 a_fmt_ff == rpc_pkg::FMT_1S7D || a_fmt_ff == rpc_pkg::FMT_2S7D;
  wire wait_ok = a_wait_ff <= rpc_pkg::WAIT_MAX_MS || a_wait_ff == rpc_pkg::WAIT_FROM_MSG;
  wire cfg_ok  = stn_ok & baud_ok & fmt_ok & (a_par_ff <= rpc_pkg::PAR_EVEN) & wait_ok &
                 (a_term_ff <= rpc_pkg::TERM_CRLF);
  wire stop2   = a_fmt_ff == rpc_pkg::FMT_2S8D || a_fmt_ff == rpc_pkg::FMT_2S7D;
  wire data7   = a_fmt_ff == rpc_pkg::FMT_1S7D || a_fmt_ff == rpc_pkg::FMT_2S7D;
  wire par_on  = a_par_ff != rpc_pkg::PAR_NONE;
  wire [3:0] nbits = 4'd1 + (data7 ? 4'd7 : 4'd8) + {3'd0, par_on} + (stop2 ? 4'd2 : 4'd1);
  wire [15:0] div = (a_baud_ff == rpc_pkg::BAUD_48)  ? 16'(DIV_48)  :
                    (a_baud_ff == rpc_pkg::BAUD_96)  ? 16'(DIV_96)  :
                    (a_baud_ff == rpc_pkg::BAUD_384) ? 16'(DIV_384) : 16'(DIV_192);
  wire [13:0] wait_ms = (a_wait_ff == rpc_pkg::WAIT_FROM_MSG) ? {6'd0, msgw_ff} : a_wait_ff;

  // read mux
  logic tx_busy;
  wire [7:0] status = {tx_busy, ~buf_ready, match_ff, ovr_ff, ferr_ff, perr_ff, rxv_ff, cfg_ok};
  wire [31:0] rmux = hit_stn  ? {24'd0, stn_ff}  : hit_baud ? {23'd0, baud_ff} :
                     hit_fmt  ? {28'd0, fmt_ff}  : hit_par  ? {30'd0, par_ff}  :
                     hit_wait ? {18'd0, wait_ff} : hit_term ? {30'd0, term_ff} :
                     hit_prot ? {31'd0, prot_ff} : hit_sts  ? {24'd0, status}  :
                     hit_rxd  ? {24'd0, rxd_ff}  : hit_msgw ? {24'd0, msgw_ff} : 32'd0;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff  <= do_ack;
      rdat_ff <= (do_ack & ~i_wb_we) ? rmux : rdat_ff;
    end
  end
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  // written settings; the line keeps the old ones until a port reset, except the message wait, which it uses at once
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stn_ff  <= rpc_pkg::RST_STATION;
      baud_ff <= rpc_pkg::RST_BAUD;
      fmt_ff  <= rpc_pkg::RST_FRAME;
      par_ff  <= rpc_pkg::RST_PARITY;
      wait_ff <= rpc_pkg::RST_WAIT;
      term_ff <= rpc_pkg::RST_TERM;
      prot_ff <= rpc_pkg::RST_PROTOCOL;
      msgw_ff <= rpc_pkg::RST_MSG_WAIT;
    end else if (wr) begin
      if (hit_stn  && i_wb_sel[0]) stn_ff  <= i_wb_dat[7:0];
      if (hit_baud && i_wb_sel[0]) baud_ff[7:0] <= i_wb_dat[7:0];
      if (hit_baud && i_wb_sel[1]) baud_ff[8]   <= i_wb_dat[8];
      if (hit_fmt  && i_wb_sel[0]) fmt_ff  <= i_wb_dat[3:0];
      if (hit_par  && i_wb_sel[0]) par_ff  <= i_wb_dat[1:0];
      if (hit_wait && i_wb_sel[0]) wait_ff[7:0]  <= i_wb_dat[7:0];
      if (hit_wait && i_wb_sel[1]) wait_ff[13:8] <= i_wb_dat[13:8];
      if (hit_term && i_wb_sel[0]) term_ff <= i_wb_dat[1:0];
      if (hit_prot && i_wb_sel[0]) prot_ff <= i_wb_dat[0];
      if (hit_msgw && i_wb_sel[0]) msgw_ff <= i_wb_dat[7:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_stn_ff  <= rpc_pkg::RST_STATION;
      a_baud_ff <= rpc_pkg::RST_BAUD;
      a_fmt_ff  <= rpc_pkg::RST_FRAME;
      a_par_ff  <= rpc_pkg::RST_PARITY;
      a_wait_ff <= rpc_pkg::RST_WAIT;
      a_term_ff <= rpc_pkg::RST_TERM;
      a_prot_ff <= rpc_pkg::RST_PROTOCOL;
    end else if (port_rst) begin
      a_stn_ff  <= stn_ff;
      a_baud_ff <= baud_ff;
      a_fmt_ff  <= fmt_ff;
      a_par_ff  <= par_ff;
      a_wait_ff <= wait_ff;
      a_term_ff <= term_ff;
      a_prot_ff <= prot_ff;
    end
  end

  // two-entry transmit buffer; bit 8 marks the last byte of a message
  logic [8:0] buf_ff [2];
  logic       bwp_ff, brp_ff;
  logic [1:0] bcnt_ff;
  logic       buf_pop;
  wire        buf_valid = bcnt_ff != 2'd0;
  assign buf_ready = bcnt_ff != 2'd2;
  wire [8:0]  buf_head  = buf_ff[brp_ff];
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      buf_ff[0] <= 9'h0;
      buf_ff[1] <= 9'h0;
      bwp_ff    <= 1'b0;
      brp_ff    <= 1'b0;
      bcnt_ff   <= 2'd0;
    end else begin
      if (buf_push) buf_ff[bwp_ff] <= i_wb_dat[8:0];
      bwp_ff  <= bwp_ff ^ buf_push;
      brp_ff  <= brp_ff ^ buf_pop;
      bcnt_ff <= bcnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // frame builder, lsb first from bit 0
  function automatic logic [11:0] rpc_frame(input logic [7:0] d, input logic d7,
                                            input logic [1:0] par);
    logic [11:0] f;
    logic [7:0]  dm;
    logic        p;
    f  = 12'hfff;
    dm = d7 ? {1'b0, d[6:0]} : d;
    p  = (par == rpc_pkg::PAR_ODD) ? ~^dm : ^dm;
    f[0] = 1'b0;
    if (d7) begin
      f[7:1] = dm[6:0];
      if (par != rpc_pkg::PAR_NONE) f[8] = p;
    end else begin
      f[8:1] = dm;
      if (par != rpc_pkg::PAR_NONE) f[9] = p;
    end
    return f;
  endfunction : rpc_frame

  // millisecond gap timer since last received byte
  logic [15:0] mspre_ff;
  logic [7:0]  gap_ms_ff;
  logic        rx_done;
  wire         ms_tick = mspre_ff == 16'(CYC_MS - 1);
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mspre_ff  <= 16'h0;
      gap_ms_ff <= 8'h0;
    end else begin
      mspre_ff  <= (ms_tick | rx_done) ? 16'h0 : mspre_ff + 16'h1;
      gap_ms_ff <= rx_done ? 8'h0 : (ms_tick && gap_ms_ff != 8'hff) ? gap_ms_ff + 8'h1 : gap_ms_ff;
    end
  end

  // transmitter
  rpc_tx_e     tx_st_ff;
  logic [11:0] tsh_ff;
  logic [3:0]  tleft_ff;
  logic [15:0] tdiv_ff;
  logic [1:0]  tq_ff;
  logic        first_ff;
  wire  term_due  = tq_ff != 2'd0;
  wire  have_char = buf_valid | term_due;
  wire  [7:0] term_char = (tq_ff == 2'd1) ? rpc_pkg::CHAR_LF : rpc_pkg::CHAR_CR;
  wire  [7:0] tx_char   = term_due ? term_char : buf_head[7:0];
  wire  wait_done = !first_ff || ({6'd0, gap_ms_ff} >= wait_ms);
  // not equality: a port reset may shorten the bit time mid-frame
  wire  tbit_end  = tdiv_ff >= div - 16'h1;
  wire  tx_load   = (tx_st_ff == TX_WAIT) & wait_done & cfg_ok;
  assign buf_pop  = tx_load & ~term_due;
  assign tx_busy  = tx_st_ff != TX_IDLE;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_st_ff <= TX_IDLE;
      tsh_ff   <= 12'hfff;
      tleft_ff <= 4'h0;
      tdiv_ff  <= 16'h0;
      tq_ff    <= 2'd0;
      first_ff <= 1'b1;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          if (have_char && cfg_ok) tx_st_ff <= TX_WAIT;
        end
        TX_WAIT: begin
          if (tx_load) begin
            tsh_ff   <= rpc_frame(tx_char, data7, a_par_ff);
            tleft_ff <= nbits;
            tdiv_ff  <= 16'h0;
            tx_st_ff <= TX_BITS;
            first_ff <= 1'b0;
            if (term_due) begin
              tq_ff    <= (tq_ff == 2'd3) ? 2'd1 : 2'd0;
              first_ff <= tq_ff != 2'd3;
            end else if (buf_head[8]) begin
              tq_ff    <= (a_term_ff == rpc_pkg::TERM_CR)   ? 2'd2 :
                          (a_term_ff == rpc_pkg::TERM_CRLF) ? 2'd3 : 2'd0;
              first_ff <= a_term_ff == rpc_pkg::TERM_NONE;
            end
          end
        end
        TX_BITS: begin
          tdiv_ff <= tbit_end ? 16'h0 : tdiv_ff + 16'h1;
          if (tbit_end) begin
            tsh_ff   <= {1'b1, tsh_ff[11:1]};
            tleft_ff <= tleft_ff - 4'h1;
            if (tleft_ff == 4'h1) tx_st_ff <= have_char ? TX_WAIT : TX_IDLE;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end
  assign o_transmit_pair   = (tx_st_ff == TX_BITS) ? tsh_ff[0] : 1'b1;
  assign o_transmit_enable = tx_st_ff == TX_BITS;

  // receiver: two-stage synchroniser, then edge detect on the second stage
  logic       rs1_ff, rs2_ff, rs3_ff;
  rpc_rx_e    rx_st_ff;
  logic [11:0] rsh_ff;
  logic [3:0] rcnt_ff;
  logic [15:0] rdiv_ff;
  logic [5:0] idle_ff;
  logic       infrm_ff;
  wire  rx_fall  = rs3_ff & ~rs2_ff;
  wire  rbit_end = rdiv_ff >= div - 16'h1;
  wire  rhalf    = rdiv_ff == {1'b0, div[15:1]};
  wire  rsample  = (rx_st_ff == RX_BITS) & rhalf;
  assign rx_done = rsample & (rcnt_ff == nbits - 4'h1);
  wire  [11:0] rfull = {rs2_ff, rsh_ff[11:1]};
  wire  [11:0] rfa   = rfull >> (4'd12 - nbits);
  wire  [7:0]  rdata = data7 ? {1'b0, rfa[7:1]} : rfa[8:1];
  wire  rpbit  = data7 ? rfa[8] : rfa[9];
  wire  rperr  = par_on & (rpbit != ((a_par_ff == rpc_pkg::PAR_ODD) ? ~^rdata : ^rdata));
  wire  rferr  = ~rfa[nbits - 4'h1] | (stop2 & ~rfa[nbits - 4'h2]);
  wire  msg_first = idle_ff >= 6'(rpc_pkg::GAP_BITS);
  wire  addr_hit  = rdata == a_stn_ff;
  wire  take      = rx_done & cfg_ok & ~rperr & ~rferr & (msg_first ? addr_hit : infrm_ff);
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rs1_ff   <= 1'b1;
      rs2_ff   <= 1'b1;
      rs3_ff   <= 1'b1;
      rx_st_ff <= RX_IDLE;
      rsh_ff   <= 12'hfff;
      rcnt_ff  <= 4'h0;
      rdiv_ff  <= 16'h0;
      idle_ff  <= 6'h3f;
      infrm_ff <= 1'b0;
    end else begin
      rs1_ff <= i_receive_pair;
      rs2_ff <= rs1_ff;
      rs3_ff <= rs2_ff;
      case (rx_st_ff)
        RX_IDLE: begin
          rdiv_ff <= rbit_end ? 16'h0 : rdiv_ff + 16'h1;
          if (rbit_end && idle_ff != 6'h3f) idle_ff <= idle_ff + 6'h1;
          if (rx_fall && cfg_ok && !tx_busy) begin
            rx_st_ff <= RX_BITS;
            rdiv_ff  <= 16'h0;
            rcnt_ff  <= 4'h0;
          end
        end
        RX_BITS: begin
          rdiv_ff <= rbit_end ? 16'h0 : rdiv_ff + 16'h1;
          if (rsample) begin
            rsh_ff  <= rfull;
            rcnt_ff <= rcnt_ff + 4'h1;
            if (rcnt_ff == 4'h0 && rs2_ff) rx_st_ff <= RX_IDLE;
          end
          if (rx_done) begin
            rx_st_ff <= RX_IDLE;
            idle_ff  <= 6'h0;
            infrm_ff <= msg_first ? addr_hit : infrm_ff;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // received byte holding register and sticky flags; a new event beats the clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rxd_ff   <= 8'h0;
      rxv_ff   <= 1'b0;
      perr_ff  <= 1'b0;
      ferr_ff  <= 1'b0;
      ovr_ff   <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      if (take) rxd_ff <= rdata;
      rxv_ff   <= take | (rxv_ff & ~rx_pop);
      perr_ff  <= (rx_done & rperr) | (perr_ff & ~(sts_clr & i_wb_dat[2]));
      ferr_ff  <= (rx_done & rferr) | (ferr_ff & ~(sts_clr & i_wb_dat[3]));
      ovr_ff   <= (take & rxv_ff & ~rx_pop) | (ovr_ff & ~(sts_clr & i_wb_dat[4]));
      match_ff <= (take & msg_first) | (match_ff & ~(sts_clr & i_wb_dat[5]));
    end
  end
endmodule : rpc_port

// ### rpc_port_monitor.sv
// concurrent checks on the pins of the operator panel port
`timescale 1ns/100ps
module rpc_port_monitor #(
  parameter int P_CLK_HZ = rpc_pkg::CLOCK_HZ
) (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  // register bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // line
  input wire logic        i_receive_pair,
  input wire logic        o_transmit_pair,
  input wire logic        o_transmit_enable
);
  // shortest legal frame, less one cycle of slack for the enable edge
  localparam int MIN_FRAME = 9 * (P_CLK_HZ / 38400) - 1;
  // wide enough for the slowest frame at the full clock rate
  logic [31:0] en_cnt_ff;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) en_cnt_ff <= 32'h0;
    else if (!o_transmit_enable) en_cnt_ff <= 32'h0;
    else en_cnt_ff <= en_cnt_ff + 32'h1;
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  AST_ACK_PROMPT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    && i_wb_adr != rpc_pkg::OFS_TX_DATA |=> o_wb_ack) else $error("register ack late");
  AST_IDLE_HIGH: assert property (!o_transmit_enable |-> o_transmit_pair)
    else $error("line not high while idle");
  AST_START_LOW: assert property ($rose(o_transmit_enable) |-> !o_transmit_pair [*8])
    else $error("start bit not low");
  AST_STOP_HIGH: assert property ($fell(o_transmit_enable)
    |-> $past(o_transmit_pair) && $past(o_transmit_pair, 8)) else $error("stop bit not high");
  AST_FRAME_LEN: assert property ($fell(o_transmit_enable) |-> en_cnt_ff >= MIN_FRAME)
    else $error("frame too short");
  AST_QUIET_RESET: assert property ($rose(i_reset_n) |-> !o_transmit_enable [*4])
    else $error("transmit right after reset");
  cover property ($rose(o_transmit_enable));
  cover property (o_wb_ack && !i_wb_we);
  cover property ($fell(i_receive_pair) && !o_transmit_enable);
endmodule : rpc_port_monitor
bind rpc_port rpc_port_monitor #(.P_CLK_HZ(P_CLK_HZ)) u_monitor (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_receive_pair(i_receive_pair),
  .o_transmit_pair(o_transmit_pair), .o_transmit_enable(o_transmit_enable));

// ### rpc_host_model.sv
// host model: half-duplex bus master that sends and decodes characters
`timescale 1ns/100ps
module rpc_host_model (
  // clock
  input  wire logic i_clock,
  // pair
  input  wire logic i_dev_line,
  input  wire logic i_dev_enable,
  output logic      o_host_line
);
  int         bit_clk = 52;
  int         data_bits = 8;
  int         stop_bits = 2;
  int         line_errs = 0;
  logic [1:0] parity = rpc_pkg::PAR_EVEN;
  logic       sending = 1'b0;
  logic [7:0] rx_q[$];
  initial o_host_line = 1'b1;
  function automatic logic par_of(input logic [7:0] d);
    return (parity == rpc_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction : par_of
  task automatic put(input logic b);
    @(posedge i_clock);
    o_host_line <= b;
    repeat (bit_clk - 1) @(posedge i_clock);
  endtask : put
  // line rests high between characters: the host drives 1 from the start and after each stop bit
  task automatic send_byte(input logic [7:0] d, input logic bad_par);
    sending = 1'b1;
    put(1'b0);
    for (int i = 0; i < data_bits; i++) put(d[i]);
    if (parity != rpc_pkg::PAR_NONE)
      put(par_of(d & ((data_bits == 7) ? 8'h7f : 8'hff)) ^ bad_par);
    repeat (stop_bits) put(1'b1);
    sending = 1'b0;
  endtask : send_byte
  initial begin
    logic [7:0] d;
    forever begin
      @(posedge i_clock);
      // never listens to its own transmission
      if (!sending && i_dev_enable && !i_dev_line) begin
        d = 8'h00;
        repeat (bit_clk / 2) @(posedge i_clock);
        for (int i = 0; i < data_bits; i++) begin
          repeat (bit_clk) @(posedge i_clock);
          d[i] = i_dev_line;
        end
        if (parity != rpc_pkg::PAR_NONE) begin
          repeat (bit_clk) @(posedge i_clock);
          if (i_dev_line !== par_of(d)) line_errs++;
        end
        repeat (bit_clk) @(posedge i_clock);
        if (i_dev_line !== 1'b1) line_errs++;
        rx_q.push_back(d);
      end
    end
  end
endmodule : rpc_host_model

// ### rpc_port_tb.sv
// self-checking bench of the operator panel port
`timescale 1ns/100ps
module rpc_port_tb;
  localparam int P_HZ = 1000000;
  logic        i_clock, i_reset_n, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd, c;
  logic        o_wb_ack, rx_line, tx_line, tx_en;
  logic [31:0] lfsr = 32'hbe11;
  int          n_errors = 0;
  int          tests_run = 0;
  int          t0;
  logic [31:0] rst_tab[7] = '{32'h0, 32'hc0, 32'h1, 32'h2, 32'h270f, 32'h1, 32'h0};
  logic [3:0]  fmt_tab[4] = '{4'h0, 4'h1, 4'ha, 4'hb};
  logic [8:0]  baud_tab[4] = '{9'h030, 9'h060, 9'h0c0, 9'h180};
  rpc_port #(.P_CLK_HZ(P_HZ)) DUT (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_receive_pair(rx_line),
    .o_transmit_pair(tx_line), .o_transmit_enable(tx_en));
  rpc_host_model host (.i_clock(i_clock), .i_dev_line(tx_line), .i_dev_enable(tx_en),
    .o_host_line(rx_line));
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  // seven data bits arrive with the top bit clear
  function automatic logic [31:0] exp_char(input logic [7:0] d, input logic [3:0] f);
    return f[3] ? {25'h0, d[6:0]} : {24'h0, d};
  endfunction : exp_char
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int t;
    t = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_clock);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 20000);
    if (t >= 20000) begin
      n_errors++;
      wrap_up();
    end
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clock);
  endtask : wb
  task automatic get_char(output logic [31:0] ch);
    int t;
    t = 0;
    while (host.rx_q.size() == 0 && t < 40000) begin
      @(posedge i_clock);
      t++;
    end
    ch = (host.rx_q.size() > 0) ? {24'h0, host.rx_q.pop_front()} : 32'hffff_ffff;
  endtask : get_char
  // settings act only after the port reset, so the host follows at the same moment
  task automatic apply(input logic [3:0] f, input logic [1:0] p, input logic [8:0] b);
    wb(rpc_pkg::OFS_FRAME, 1'b1, {28'h0, f});
    wb(rpc_pkg::OFS_PARITY, 1'b1, {30'h0, p});
    wb(rpc_pkg::OFS_BAUD, 1'b1, {23'h0, b});
    wb(rpc_pkg::OFS_CONTROL, 1'b1, 32'h1);
    host.data_bits = f[3] ? 7 : 8;
    host.stop_bits = f[0] ? 2 : 1;
    host.parity = p;
    host.bit_clk = P_HZ / (b * 100);
  endtask : apply
  task automatic rx_probe(input logic [7:0] d, input logic bad, input logic [31:0] exp);
    repeat (40 * host.bit_clk) @(posedge i_clock);
    host.send_byte(d, bad);
    repeat (4 * host.bit_clk) @(posedge i_clock);
    wb(rpc_pkg::OFS_STATUS, 1'b0, 32'h0);
    check("rx status", exp, rd & 32'h3f);
    wb(rpc_pkg::OFS_STATUS, 1'b1, 32'h3c);
  endtask : rx_probe
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    repeat (80000) @(posedge i_clock);
    n_errors++;
    wrap_up();
  end
  initial begin
    {i_reset_n, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} = '0;
    i_wb_sel = 4'hf;
    host.bit_clk = P_HZ / 19200;
    repeat (16) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    for (int i = 0; i < 7; i++) begin
      wb(8'(i * 4), 1'b0, 32'h0);
      check("reset value", rst_tab[i], rd);
    end
    wb(8'h30, 1'b0, 32'h0);
    check("unmapped", 32'h0, rd);
    wb(rpc_pkg::OFS_TX_DATA, 1'b1, 32'h141);
    get_char(c);
    check("tx char", 32'h41, c);
    get_char(c);
    check("cr", 32'h0d, c);
    wb(rpc_pkg::OFS_FRAME, 1'b1, 32'h0);
    wb(rpc_pkg::OFS_FRAME, 1'b0, 32'h0);
    check("frame readback", 32'h0, rd);
    wb(rpc_pkg::OFS_TX_DATA, 1'b1, 32'h1b5);
    get_char(c);
    check("old format char", 32'hb5, c);
    get_char(c);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt_rand(lfsr);
      wb(rpc_pkg::OFS_TERM, 1'b1, 32'(i % 3));
      apply(fmt_tab[i], 2'(i % 3), baud_tab[i]);
      wb(rpc_pkg::OFS_STATUS, 1'b0, 32'h0);
      check("cfg valid", 32'h1, rd & 32'h1);
      wb(rpc_pkg::OFS_TX_DATA, 1'b1, {23'h0, 1'b1, lfsr[7:0]});
      get_char(c);
      check("tx char", exp_char(lfsr[7:0], fmt_tab[i]), c);
      if (i % 3 != 0) get_char(c);
      if (i % 3 != 0) check("cr", 32'h0d, c);
      if (i % 3 == 2) get_char(c);
      if (i % 3 == 2) check("lf", 32'h0a, c);
    end
    for (int i = 0; i < 3; i++) wb(rpc_pkg::OFS_TX_DATA, 1'b1, 32'(8'h61 + i));
    wb(rpc_pkg::OFS_STATUS, 1'b0, 32'h0);
    check("buffer full", 32'h40, rd & 32'h40);
    wb(rpc_pkg::OFS_TX_DATA, 1'b1, 32'h64);
    for (int i = 0; i < 4; i++) begin
      get_char(c);
      check("buffered char", 32'(8'h61 + i), c);
    end
    wb(rpc_pkg::OFS_STATION, 1'b1, 32'h5);
    apply(rpc_pkg::FMT_2S8D, rpc_pkg::PAR_EVEN, rpc_pkg::BAUD_192);
    rx_probe(8'h05, 1'b0, 32'h23);
    wb(rpc_pkg::OFS_RX_DATA, 1'b0, 32'h0);
    check("rx data", 32'h05, rd);
    rx_probe(8'h07, 1'b0, 32'h01);
    rx_probe(8'h05, 1'b1, 32'h05);
    wb(rpc_pkg::OFS_STATION, 1'b1, 32'd200);
    apply(rpc_pkg::FMT_2S8D, rpc_pkg::PAR_EVEN, rpc_pkg::BAUD_192);
    wb(rpc_pkg::OFS_STATUS, 1'b0, 32'h0);
    check("cfg invalid", 32'h0, rd & 32'h1);
    wb(rpc_pkg::OFS_PROTOCOL, 1'b1, 32'h1);
    apply(rpc_pkg::FMT_2S8D, rpc_pkg::PAR_EVEN, rpc_pkg::BAUD_192);
    wb(rpc_pkg::OFS_STATUS, 1'b0, 32'h0);
    check("cfg valid rtu", 32'h1, rd & 32'h1);
    wb(rpc_pkg::OFS_TX_DATA, 1'b1, 32'h100);
    get_char(c);
    check("last char", 32'h0, c);
    wb(rpc_pkg::OFS_WAIT, 1'b1, 32'h3);
    apply(rpc_pkg::FMT_2S8D, rpc_pkg::PAR_EVEN, rpc_pkg::BAUD_192);
    rx_probe(8'h05, 1'b0, 32'h01);
    wb(rpc_pkg::OFS_TX_DATA, 1'b1, 32'h142);
    t0 = 0;
    while (tx_en !== 1'b1 && t0 < 4000) begin
      @(posedge i_clock);
      t0++;
    end
    // 3 ms at this clock, less the time already spent after the byte
    check("response wait", 32'h1, 32'(t0 > 2000 && t0 < 3000));
    get_char(c);
    check("late char", 32'h42, c);
    check("line errors", 32'h0, 32'(host.line_errs));
    wrap_up();
  end
endmodule : rpc_port_tb
